// ===== verilog/rls_pkg.sv
/*
 Constants, register map and state type of the result logger and statistics unit.
 Assumes one clock domain; all inputs come from logic on that clock.
*/
package rls_pkg;
   // ----------------------------------------
   // Widths and depths
   // ----------------------------------------
   localparam int DW = 16;
   localparam int NPT = 32;
   localparam int PW = 5;
   localparam int NCH = 4;
   localparam int NST = 16;
   localparam int FB = 14;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_LEN = 12'h004;
   localparam logic [11:0] OFS_AVG = 12'h008;
   localparam logic [11:0] OFS_STATUS = 12'h00C;
   localparam logic [11:0] OFS_IRQ_STS = 12'h010;
   localparam logic [11:0] OFS_IRQ_MSK = 12'h014;
   localparam logic [11:0] OFS_ROT_COS = 12'h018;
   localparam logic [11:0] OFS_ROT_SIN = 12'h01C;
   localparam logic [11:0] OFS_SHIFT_I = 12'h020;
   localparam logic [11:0] OFS_SHIFT_Q = 12'h024;
   localparam logic [11:0] OFS_SCALE_I = 12'h028;
   localparam logic [11:0] OFS_SCALE_Q = 12'h02C;
   localparam logic [11:0] OFS_STAT_LEN = 12'h030;
   localparam logic [11:0] OFS_MAP_LO = 12'h034;
   localparam logic [11:0] OFS_MAP_HI = 12'h038;
   localparam logic [11:0] OFS_STAT_CNT = 12'h03C;
   localparam logic [11:0] OFS_STAT_TOT = 12'h040;
   localparam logic [7:0] PAGE_ONES = 8'h08;
   localparam logic [7:0] PAGE_FLIPS = 8'h09;
   localparam logic [7:0] PAGE_ERRS = 8'h0A;
   localparam logic [3:0] PAGE_RES = 4'h1;
   // ----------------------------------------
   // Control bits and interrupt bits
   // ----------------------------------------
   localparam int CB_RUN = 0;
   localparam int CB_CLR = 1;
   localparam int CB_MODE = 2;
   localparam int CB_SRC = 4;
   localparam int CB_SEN = 8;
   localparam int CB_SCLR = 9;
   localparam int IB_ACQ = 0;
   localparam int IB_DONE = 1;
   localparam int IB_SDONE = 2;
   localparam logic [2:0] SRC_ROT = 3'h0;
   localparam logic [2:0] SRC_XT = 3'h1;
   localparam logic [2:0] SRC_THR = 3'h2;
   localparam logic [2:0] SRC_XCOR = 3'h3;
   localparam logic [2:0] SRC_TCOR = 3'h4;
   localparam logic MODE_CYC = 1'b0;
   localparam logic [15:0] ONE16 = 16'h0001;
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef enum logic [1:0] {LG_IDLE, LG_RUN, LG_DONE} rls_lg_t;
   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic irq;
      logic acq;
      rls_lg_t fsm;
      logic done;
      logic run;
      logic mode;
      logic [2:0] src;
      logic sen;
      logic [PW:0] len;
      logic [15:0] avg;
      logic [PW-1:0] idx;
      logic [15:0] pass;
      logic [15:0] cosv;
      logic [15:0] sinv;
      logic [15:0] shi;
      logic [15:0] shq;
      logic [15:0] sci;
      logic [15:0] scq;
      logic [2:0] sts;
      logic [2:0] msk;
      logic [NPT-1:0][31:0] acci;
      logic [NPT-1:0][31:0] accq;
      logic [NPT-1:0][DW-1:0] resi;
      logic [NPT-1:0][DW-1:0] resq;
      logic [15:0] slen;
      logic [15:0] scnt;
      logic [NST*NCH-1:0] smap;
      logic [NCH-1:0] prev;
      logic [NCH-1:0][15:0] ones;
      logic [NCH-1:0][15:0] flips;
      logic [NCH-1:0][15:0] errs;
      logic [15:0] tot;
   } rls_state_t;
endpackage

// ===== verilog/rls_top.sv
/*
 Result logger with averaging and I/Q post processing, plus the multi-channel
 state statistics unit, behind a classic Wishbone slave.
 Assumes the processing chain drives its results on this clock with one-cycle valids.
*/
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
// Notes on behaviour
// - Run starts collection; clear empties and restarts
// - Source selector picks one of five probes
// - Length sets number of recorded points
// - Averages sets results combined per point
// - Progress index and point-recorded indication
// - Cyclic: point k averages k, k+M, ...
// - Sequential: consecutive blocks of Averages results
// - Recorded value rotated by programmable angle
// - Separate I and Q offsets added
// - Separate I and Q gains applied
// - Statistics count only when enabled; clear zeroes
// - Statistics stop after programmed measurement count
// - Count ones per channel
// - Count flips per channel
// - Count state errors per channel
// - Total errors once per measurement, all channels
// - State table indexed by previous state
// - Averages of one or less: single result
`timescale 1ns/10ps
module rls_top
   import rls_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rot_valid_i,
   input wire logic [DW-1:0] rot_i_i,
   input wire logic [DW-1:0] rot_q_i,
   input wire logic xt_valid_i,
   input wire logic [DW-1:0] xt_i_i,
   input wire logic [DW-1:0] xt_q_i,
   input wire logic thr_valid_i,
   input wire logic [NCH-1:0] thr_state_i,
   input wire logic xcor_valid_i,
   input wire logic [DW-1:0] xcor_i,
   input wire logic tcor_valid_i,
   input wire logic [DW-1:0] tcor_i,
   output logic irq_o,
   output logic acquired_o,
   output logic done_o,
   output logic [PW-1:0] progress_o
);
   rls_state_t q;
   rls_state_t n;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
         begin
            r[8*b +: 8] = dat[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [DW-1:0] post(input logic signed [31:0] a, input logic signed [31:0] b,
                                          input logic signed [15:0] ca, input logic signed [15:0] cb,
                                          input logic signed [15:0] sh, input logic signed [15:0] sc);
      logic signed [31:0] r;
      r = (ca * a + cb * b) >>> FB;
      r = r + 32'(sh);
      r = (r * 32'(sc)) >>> FB;
      return r[DW-1:0];
   endfunction

   always_comb
   begin
      logic wr;
      logic rd;
      logic [31:0] w;
      logic [31:0] r;
      logic [15:0] eavg;
      logic [PW:0] elen;
      logic sv;
      logic signed [31:0] si;
      logic signed [31:0] sq;
      logic signed [31:0] ai;
      logic signed [31:0] aq;
      logic signed [31:0] mi;
      logic signed [31:0] mq;
      logic first;
      logic last;
      logic wrap;
      logic [NCH-1:0] pred;
      logic [NCH-1:0] serr;
      logic [2:0] ev;
      n = q;
      n.ack = wb_cyc_i & wb_stb_i & ~q.ack;
      n.acq = 1'b0;
      ev = 3'h0;
      r = 32'h0000_0000;
      wr = wb_cyc_i & wb_stb_i & wb_we_i & ~q.ack;
      rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~q.ack;
      w = wb_dat_i;
      // ----------------------------------------
      // Register writes
      // ----------------------------------------
      if (wr)
      begin
         case (wb_adr_i)
            OFS_CTRL:
            begin
               if (wb_sel_i[0])
               begin
                  n.run = w[CB_RUN];
                  n.mode = w[CB_MODE];
                  n.src = w[CB_SRC +: 3];
               end
               if (wb_sel_i[1])
               begin
                  n.sen = w[CB_SEN];
               end
            end
            OFS_LEN: n.len = (PW+1)'(merge(32'(q.len), w, wb_sel_i));
            OFS_AVG: n.avg = 16'(merge(32'(q.avg), w, wb_sel_i));
            OFS_IRQ_STS: n.sts = q.sts & ~(w[2:0] & {3{wb_sel_i[0]}});
            OFS_IRQ_MSK: n.msk = 3'(merge(32'(q.msk), w, wb_sel_i));
            OFS_ROT_COS: n.cosv = 16'(merge(32'(q.cosv), w, wb_sel_i));
            OFS_ROT_SIN: n.sinv = 16'(merge(32'(q.sinv), w, wb_sel_i));
            OFS_SHIFT_I: n.shi = 16'(merge(32'(q.shi), w, wb_sel_i));
            OFS_SHIFT_Q: n.shq = 16'(merge(32'(q.shq), w, wb_sel_i));
            OFS_SCALE_I: n.sci = 16'(merge(32'(q.sci), w, wb_sel_i));
            OFS_SCALE_Q: n.scq = 16'(merge(32'(q.scq), w, wb_sel_i));
            OFS_STAT_LEN: n.slen = 16'(merge(32'(q.slen), w, wb_sel_i));
            OFS_MAP_LO: n.smap[31:0] = merge(q.smap[31:0], w, wb_sel_i);
            OFS_MAP_HI: n.smap[63:32] = merge(q.smap[63:32], w, wb_sel_i);
            default:
            begin
            end
         endcase
      end
      // ----------------------------------------
      // Register reads
      // ----------------------------------------
      if (rd)
      begin
         case (wb_adr_i)
            OFS_CTRL: r = 32'({q.sen, 1'b0, q.src, 1'b0, q.mode, 1'b0, q.run});
            OFS_LEN: r = 32'(q.len);
            OFS_AVG: r = 32'(q.avg);
            OFS_STATUS: r = 32'({q.pass, 3'h0, q.idx, 6'h00, (q.fsm == LG_DONE), (q.fsm == LG_RUN)});
            OFS_IRQ_STS: r = 32'(q.sts);
            OFS_IRQ_MSK: r = 32'(q.msk);
            OFS_ROT_COS: r = 32'(q.cosv);
            OFS_ROT_SIN: r = 32'(q.sinv);
            OFS_SHIFT_I: r = 32'(q.shi);
            OFS_SHIFT_Q: r = 32'(q.shq);
            OFS_SCALE_I: r = 32'(q.sci);
            OFS_SCALE_Q: r = 32'(q.scq);
            OFS_STAT_LEN: r = 32'(q.slen);
            OFS_MAP_LO: r = q.smap[31:0];
            OFS_MAP_HI: r = q.smap[63:32];
            OFS_STAT_CNT: r = 32'(q.scnt);
            OFS_STAT_TOT: r = 32'(q.tot);
            default:
            begin
               if (wb_adr_i[11:8] == PAGE_RES)
               begin
                  r = wb_adr_i[2] ? 32'(signed'(q.resq[wb_adr_i[7:3]])) : 32'(signed'(q.resi[wb_adr_i[7:3]]));
               end
               else if (wb_adr_i[11:4] == PAGE_ONES)
               begin
                  r = 32'(q.ones[wb_adr_i[3:2]]);
               end
               else if (wb_adr_i[11:4] == PAGE_FLIPS)
               begin
                  r = 32'(q.flips[wb_adr_i[3:2]]);
               end
               else if (wb_adr_i[11:4] == PAGE_ERRS)
               begin
                  r = 32'(q.errs[wb_adr_i[3:2]]);
               end
            end
         endcase
      end
      n.rdat = rd ? r : 32'h0000_0000;
      // ----------------------------------------
      // Logger
      // ----------------------------------------
      eavg = (q.avg > ONE16) ? q.avg : ONE16;
      elen = (q.len == '0) ? (PW+1)'(1) : ((q.len > (PW+1)'(NPT)) ? (PW+1)'(NPT) : q.len);
      case (q.src)
         SRC_ROT:
         begin
            sv = rot_valid_i;
            si = 32'(signed'(rot_i_i));
            sq = 32'(signed'(rot_q_i));
         end
         SRC_XT:
         begin
            sv = xt_valid_i;
            si = 32'(signed'(xt_i_i));
            sq = 32'(signed'(xt_q_i));
         end
         SRC_THR:
         begin
            sv = thr_valid_i;
            si = 32'(thr_state_i);
            sq = 32'h0000_0000;
         end
         SRC_XCOR:
         begin
            sv = xcor_valid_i;
            si = 32'(signed'(xcor_i));
            sq = 32'h0000_0000;
         end
         SRC_TCOR:
         begin
            sv = tcor_valid_i;
            si = 32'(signed'(tcor_i));
            sq = 32'h0000_0000;
         end
         default:
         begin
            sv = 1'b0;
            si = 32'h0000_0000;
            sq = 32'h0000_0000;
         end
      endcase
      // Pass counts passes in cyclic mode and contributions in sequential mode
      first = (q.pass == 16'h0000);
      last = (q.pass == eavg - ONE16);
      wrap = (32'(q.idx) == 32'(elen) - 1);
      ai = (first ? 32'h0000_0000 : q.acci[q.idx]) + si;
      aq = (first ? 32'h0000_0000 : q.accq[q.idx]) + sq;
      mi = ai / signed'(32'(eavg));
      mq = aq / signed'(32'(eavg));
      case (q.fsm)
         LG_IDLE:
         begin
            if (q.run)
            begin
               n.fsm = LG_RUN;
            end
         end
         LG_RUN:
         begin
            if (!q.run)
            begin
               n.fsm = LG_IDLE;
            end
            else if (sv)
            begin
               n.acci[q.idx] = ai;
               n.accq[q.idx] = aq;
               if (last)
               begin
                  n.resi[q.idx] = post(mi, mq, q.cosv, -q.sinv, q.shi, q.sci);
                  n.resq[q.idx] = post(mi, mq, q.sinv, q.cosv, q.shq, q.scq);
                  n.acq = 1'b1;
                  ev[IB_ACQ] = 1'b1;
               end
               if (q.mode == MODE_CYC)
               begin
                  n.idx = wrap ? '0 : q.idx + 1'b1;
                  n.pass = wrap ? q.pass + ONE16 : q.pass;
               end
               else
               begin
                  n.pass = last ? 16'h0000 : q.pass + ONE16;
                  n.idx = last ? (wrap ? '0 : q.idx + 1'b1) : q.idx;
               end
               if (last && wrap)
               begin
                  n.fsm = LG_DONE;
                  ev[IB_DONE] = 1'b1;
               end
            end
         end
         LG_DONE: n.fsm = LG_DONE;
         default: n.fsm = LG_IDLE;
      endcase
      if (wr && wb_adr_i == OFS_CTRL && wb_sel_i[0] && w[CB_CLR])
      begin
         n.idx = '0;
         n.pass = 16'h0000;
         n.acci = '0;
         n.accq = '0;
         n.resi = '0;
         n.resq = '0;
         n.fsm = LG_IDLE;
         ev[IB_DONE:IB_ACQ] = 2'h0;
         n.acq = 1'b0;
      end
      // ----------------------------------------
      // Statistics
      // ----------------------------------------
      pred = q.smap[32'(q.prev) * NCH +: NCH];
      serr = thr_state_i ^ pred;
      if (q.sen && thr_valid_i && q.scnt < q.slen)
      begin
         n.scnt = q.scnt + ONE16;
         n.prev = thr_state_i;
         for (int c = 0; c < NCH; c++)
         begin
            n.ones[c] = q.ones[c] + 16'(thr_state_i[c]);
            if (q.scnt != 16'h0000)
            begin
               n.flips[c] = q.flips[c] + 16'(thr_state_i[c] ^ q.prev[c]);
               n.errs[c] = q.errs[c] + 16'(serr[c]);
            end
         end
         if (q.scnt != 16'h0000 && serr != '0)
         begin
            n.tot = q.tot + ONE16;
         end
         if (q.scnt + ONE16 == q.slen)
         begin
            ev[IB_SDONE] = 1'b1;
         end
      end
      if (wr && wb_adr_i == OFS_CTRL && wb_sel_i[1] && w[CB_SCLR])
      begin
         n.scnt = 16'h0000;
         n.prev = '0;
         n.ones = '0;
         n.flips = '0;
         n.errs = '0;
         n.tot = 16'h0000;
         ev[IB_SDONE] = 1'b0;
      end
      // ----------------------------------------
      // Interrupt, set wins over write-one clear
      // ----------------------------------------
      n.sts = n.sts | ev;
      n.irq = |(n.sts & n.msk);
      n.done = (n.fsm == LG_DONE);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q <= '0;
      end
      else if (ce_i)
      begin
         q <= n;
      end
   end

   assign wb_dat_o = q.rdat;
   assign wb_ack_o = q.ack;
   assign irq_o = q.irq;
   assign acquired_o = q.acq;
   assign done_o = q.done;
   assign progress_o = q.idx;
endmodule

// ===== dv/rls_top_assertions.sv
/*
 Checker for rls_top, bound from the bench top file.
 Assumes it sees only the top module's ports, one clock domain.
*/
`timescale 1ns/10ps
module rls_top_assertions
   import rls_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_ack_o,
   input wire logic rot_valid_i,
   input wire logic xt_valid_i,
   input wire logic thr_valid_i,
   input wire logic xcor_valid_i,
   input wire logic tcor_valid_i,
   input wire logic irq_o,
   input wire logic acquired_o,
   input wire logic done_o,
   input wire logic [PW-1:0] progress_o
);
   // ----------
   // Helpers
   // ----------
   logic tk;
   logic clr;
   logic anyv;
   assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   assign clr = tk && wb_we_i && wb_adr_i == OFS_CTRL && wb_sel_i[0] && wb_dat_i[CB_CLR];
   assign anyv = rot_valid_i || xt_valid_i || thr_valid_i || xcor_valid_i || tcor_valid_i;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ----------
   // Properties
   // ----------
   a_ack_answer: assert property (tk |=> wb_ack_o) else $error("no ack after request");
   a_ack_single: assert property (wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack too long");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
   a_clr_quiet: assert property (clr |=> !acquired_o) else $error("point after clear");
   a_acq_cause: assert property (acquired_o && $past(ce_i) |-> $past(anyv)) else $error("point without sample");
   a_prog_hold: assert property (!$past(anyv) && !$past(clr) && !$past(rst_i) |-> $stable(progress_o))
      else $error("progress moved without point");
   a_done_hold: assert property (done_o && !clr |=> done_o) else $error("done left without clear");
   a_done_quiet: assert property (done_o && $past(done_o) |-> !acquired_o) else $error("point after done");
   a_done_rise: assert property ($rose(done_o) |-> acquired_o && progress_o == '0)
      else $error("done without final point");
   a_irq_fall: assert property ($fell(irq_o) |-> $past(tk && wb_we_i) || $past(tk && wb_we_i, 2))
      else $error("irq dropped without write");
endmodule

// ===== dv/rls_chain_model.sv
/*
 Model of the processing chain feeding the logger probes.
 Assumes the bench calls emit once per cycle wanted and idle after.
*/
`timescale 1ns/10ps
module rls_chain_model
   import rls_pkg::*;
(
   input wire logic clk_i,
   output logic [4:0] valid_o,
   output logic [DW-1:0] a_o,
   output logic [DW-1:0] b_o,
   output logic [NCH-1:0] st_o
);
   initial
   begin
      valid_o = 5'h00;
      a_o = 16'h0000;
      b_o = 16'h0000;
      st_o = 4'h0;
   end
   // One sample per edge; valid bit index is the source code
   task automatic emit(input logic [2:0] s, input logic [DW-1:0] a, input logic [DW-1:0] b,
      input logic [NCH-1:0] st);
      @(posedge clk_i);
      valid_o <= 5'h01 << s;
      a_o <= a;
      b_o <= b;
      st_o <= st;
   endtask
   // Stale data is inverted so nothing can lean on old values
   task automatic idle();
      @(posedge clk_i);
      valid_o <= 5'h00;
      a_o <= ~a_o;
      b_o <= ~b_o;
      st_o <= ~st_o;
   endtask
endmodule

// ===== dv/rls_top_tb.sv
/*
 Self-checking bench for rls_top: capture table, averaging, statistics, irq, reset.
 Assumes rls_chain_model as upstream and the checker bound at the foot.
*/
`timescale 1ns/10ps
module rls_top_tb
   import rls_pkg::*;
;
   typedef struct packed {logic [2:0] s; logic [15:0] cs; logic [15:0] sn; logic [15:0] sc;
      logic [15:0] a; logic [15:0] b; logic [31:0] ei; logic [31:0] eq; logic c;} rls_row_t;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [31:0] wdat = 32'h0, q, wb_dat_o;
   logic [3:0] sel = 4'h0, e;
   logic wb_ack_o, irq_o, acquired_o, done_o;
   logic [PW-1:0] progress_o;
   logic [4:0] pv;
   logic [DW-1:0] pa, pb;
   logic [NCH-1:0] pst;
   int miscompares = 0, check_count = 0, acq_n = 0, base, tot = 0;
   int ones[4], flips[4], errs[4];
   rls_row_t r;
   rls_row_t rows[7] = '{
      '{SRC_ROT, 16'h4000, 16'h0, 16'h4000, 16'h0123, 16'h0045, 32'h123, 32'h45, 1'b1},
      '{SRC_XT, 16'h4000, 16'h0, 16'h4000, 16'hFF00, 16'h0010, 32'hFFFFFF00, 32'h10, 1'b1},
      '{SRC_XCOR, 16'h4000, 16'h0, 16'h4000, 16'h0200, 16'h0077, 32'h200, 32'h0, 1'b1},
      '{SRC_TCOR, 16'h4000, 16'h0, 16'h4000, 16'h0003, 16'h0055, 32'h3, 32'h0, 1'b1},
      '{SRC_THR, 16'h4000, 16'h0, 16'h4000, 16'h0, 16'h0, 32'hA, 32'h0, 1'b1},
      '{SRC_ROT, 16'h0, 16'h4000, 16'h4000, 16'h0064, 16'h0028, 32'hFFFFFFD8, 32'h64, 1'b1},
      '{SRC_ROT, 16'h4000, 16'h0, 16'h2000, 16'h0064, 16'h0028, 32'h32, 32'h14, 1'b1}};
   logic [31:0] ex [2][4] = '{'{32'h17, 32'h5, 32'h21, 32'h7}, '{32'h12, 32'h4, 32'h26, 32'h8}};
   logic [3:0] sq [6] = '{4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'hF};
   rls_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .rot_valid_i(pv[0]), .rot_i_i(pa), .rot_q_i(pb), .xt_valid_i(pv[1]), .xt_i_i(pa), .xt_q_i(pb),
      .thr_valid_i(pv[2]), .thr_state_i(pst), .xcor_valid_i(pv[3]), .xcor_i(pa), .tcor_valid_i(pv[4]),
      .tcor_i(pa), .irq_o(irq_o), .acquired_o(acquired_o), .done_o(done_o), .progress_o(progress_o));
   rls_chain_model pm (.clk_i(clk_i), .valid_o(pv), .a_o(pa), .b_o(pb), .st_o(pst));
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i)
      if (acquired_o === 1'b1)
         acq_n <= acq_n + 1;
   // ----------
   // Tasks
   // ----------
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      check_count++;
      if (s !== x)
      begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, x);
      end
   endtask
   // Classic cycle; waits for ack however long, only the watchdog ends a hang
   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hF};
      do
      begin
         @(posedge clk_i);
      end
      while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      {cyc, stb} <= 2'b00;
   endtask
   task automatic end_of_test();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      tick(30000);
      miscompares++;
      end_of_test();
   end
   // ----------
   // Sequence
   // ----------
   initial
   begin
      tick(3);
      rst_i <= 1'b0;
      wb(1'b1, OFS_LEN, 32'h1);
      foreach (rows[k])
      begin
         r = rows[k];
         wb(1'b1, OFS_ROT_COS, {16'h0, r.cs});
         wb(1'b1, OFS_ROT_SIN, {16'h0, r.sn});
         wb(1'b1, OFS_SCALE_I, {16'h0, r.sc});
         wb(1'b1, OFS_SCALE_Q, {16'h0, r.sc});
         wb(1'b1, OFS_CTRL, 32'h2 | (32'(r.s) << CB_SRC));
         wb(1'b1, OFS_CTRL, 32'h1 | (32'(r.s) << CB_SRC));
         pm.emit(r.s == SRC_TCOR ? SRC_ROT : r.s + 3'h1, r.a, r.b, 4'h5);
         pm.idle();
         tick(3);
         chk(32'(done_o), 32'h0);
         pm.emit(r.s, r.a, r.b, 4'hA);
         pm.idle();
         tick(3);
         chk(32'(done_o), 32'h1);
         wb(1'b0, 12'h100, 32'h0);
         chk(r.c ? q : 32'h0, r.ei);
         wb(1'b0, 12'h104, 32'h0);
         chk(r.c ? q : 32'h0, r.eq);
      end
      wb(1'b1, OFS_LEN, 32'h2);
      wb(1'b1, OFS_AVG, 32'h2);
      wb(1'b1, OFS_SHIFT_I, 32'h3);
      wb(1'b1, OFS_SHIFT_Q, 32'h2);
      wb(1'b1, OFS_SCALE_I, 32'h4000);
      wb(1'b1, OFS_SCALE_Q, 32'h2000);
      for (int m = 0; m < 2; m++)
      begin
         wb(1'b1, OFS_CTRL, 32'h2 | (32'(m) << CB_MODE));
         wb(1'b1, OFS_CTRL, 32'h1 | (32'(m) << CB_MODE));
         base = acq_n;
         for (int k = 1; k < 6; k++)
            pm.emit(SRC_ROT, 16'(10 * k), 16'(4 * k), 4'h0);
         pm.idle();
         tick(3);
         chk(32'(acq_n - base), 32'h2);
         chk(32'(progress_o), 32'h0);
         for (int j = 0; j < 4; j++)
         begin
            wb(1'b0, 12'h100 + 12'(4 * j), 32'h0);
            chk(q, ex[m][j]);
         end
      end
      wb(1'b1, OFS_IRQ_STS, 32'h7);
      wb(1'b1, OFS_CTRL, 32'h0);
      pm.emit(SRC_THR, 16'h0, 16'h0, 4'hF);
      pm.idle();
      tick(2);
      wb(1'b0, OFS_STAT_CNT, 32'h0);
      chk(q, 32'h0);
      wb(1'b1, OFS_MAP_LO, 32'h87654321);
      wb(1'b1, OFS_MAP_HI, 32'h0FEDCBA9);
      wb(1'b1, OFS_STAT_LEN, 32'h5);
      wb(1'b1, OFS_CTRL, 32'h300);
      wb(1'b1, OFS_CTRL, 32'h100);
      foreach (sq[k])
         pm.emit(SRC_THR, 16'h0, 16'h0, sq[k]);
      pm.idle();
      tick(3);
      for (int k = 0; k < 5; k++)
      begin
         e = k > 0 ? sq[k - 1] + 4'h1 : sq[0];
         tot += int'(sq[k] != e);
         for (int c = 0; c < NCH; c++)
         begin
            ones[c] += int'(sq[k][c]);
            flips[c] += int'(k > 0 && sq[k][c] != sq[k - 1][c]);
            errs[c] += int'(sq[k][c] != e[c]);
         end
      end
      for (int c = 0; c < NCH; c++)
      begin
         wb(1'b0, 12'h080 + 12'(4 * c), 32'h0);
         chk(q, 32'(ones[c]));
         wb(1'b0, 12'h090 + 12'(4 * c), 32'h0);
         chk(q, 32'(flips[c]));
         wb(1'b0, 12'h0A0 + 12'(4 * c), 32'h0);
         chk(q, 32'(errs[c]));
      end
      wb(1'b0, OFS_STAT_CNT, 32'h0);
      chk(q, 32'h5);
      wb(1'b0, OFS_STAT_TOT, 32'h0);
      chk(q, 32'(tot));
      wb(1'b0, OFS_IRQ_STS, 32'h0);
      chk({q[31:1], irq_o}, 32'h4);
      wb(1'b1, OFS_IRQ_MSK, 32'h4);
      tick(2);
      chk(32'(irq_o), 32'h1);
      wb(1'b1, OFS_IRQ_STS, 32'h4);
      tick(2);
      chk(32'(irq_o), 32'h0);
      wb(1'b1, OFS_CTRL, 32'h300);
      wb(1'b0, OFS_STAT_CNT, 32'h0);
      chk(q, 32'h0);
      wb(1'b1, OFS_CTRL, 32'h3);
      pm.emit(SRC_ROT, 16'h0010, 16'h0020, 4'h0);
      pm.idle();
      tick(1);
      chk(32'(progress_o), 32'h1);
      // A sample arriving while the clock enable is low must leave no trace
      ce_i <= 1'b0;
      pm.emit(SRC_ROT, 16'h0010, 16'h0020, 4'h0);
      pm.idle();
      tick(1);
      ce_i <= 1'b1;
      chk(32'(progress_o), 32'h1);
      rst_i <= 1'b1;
      tick(3);
      rst_i <= 1'b0;
      tick(1);
      chk(32'({progress_o, done_o, irq_o}), 32'h0);
      wb(1'b0, OFS_CTRL, 32'h0);
      chk(q, 32'h0);
      wb(1'b0, 12'h7F0, 32'h0);
      chk(q, 32'h0);
      end_of_test();
   end
endmodule
bind rls_top rls_top_assertions chk_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
   .wb_ack_o(wb_ack_o), .rot_valid_i(rot_valid_i), .xt_valid_i(xt_valid_i), .thr_valid_i(thr_valid_i),
   .xcor_valid_i(xcor_valid_i), .tcor_valid_i(tcor_valid_i), .irq_o(irq_o), .acquired_o(acquired_o),
   .done_o(done_o), .progress_o(progress_o));
